// ==== design/crypto_ctl_pkg.sv ====
package crypto_ctl_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTL_LOW = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_TXTB0 = 8'h10;
  localparam logic [7:0] OFS_TXTB3 = 8'h1C;

  // Field positions of crypto_control_low.
  localparam int CTL_KEY_ORIGIN_LSB = 0;
  localparam int CTL_ERASE_BIT = 4;
  localparam int CTL_KEY_LEN_LSB = 5;
  localparam int CTL_KEY_HALF_BIT = 7;
  localparam int CTL_CTR_WIDTH_LSB = 8;

  // Field positions of the operation control register.
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_DISABLE_BIT = 1;
  localparam int CTRL_FAMILY_BIT = 2;
  localparam int CTRL_CTR_MODE_BIT = 3;

  // Interrupt status and mask bits.
  localparam int IRQ_ROLLOVER_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_W = 2;

  // Key length codes and counter geometry.
  localparam logic [1:0] KEY_LEN_00 = 2'h0;
  localparam logic [1:0] KEY_LEN_01 = 2'h1;
  localparam logic [1:0] KEY_LEN_10 = 2'h2;
  localparam logic [1:0] KEY_LEN_11 = 2'h3;
  localparam int CTR_MAX_W = 128;
  localparam logic [6:0] CTR_CODE_MAX = 7'h7F;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ==== design/key_mode_decode.sv ====
`timescale 1ns/1ns
// Decodes the key length field according to the selected cipher family.
module key_mode_decode
(
  // Selection inputs.
  input wire logic cipher_family_sel,
  input wire logic [1:0] key_length_mode,
  // Decoded key modes.
  output logic des_single,
  output logic des_two_key,
  output logic des_three_key,
  output logic aes_128,
  output logic aes_192,
  output logic aes_256,
  output logic mode_reserved
);

  // Family zero is the DES group, family one the AES group.
  always_comb
  begin
    des_single = !cipher_family_sel && key_length_mode == crypto_ctl_pkg::KEY_LEN_00;
    des_two_key = !cipher_family_sel && key_length_mode == crypto_ctl_pkg::KEY_LEN_01;
    des_three_key = !cipher_family_sel && key_length_mode == crypto_ctl_pkg::KEY_LEN_11;
    aes_128 = cipher_family_sel && key_length_mode == crypto_ctl_pkg::KEY_LEN_00;
    aes_192 = cipher_family_sel && key_length_mode == crypto_ctl_pkg::KEY_LEN_01;
    aes_256 = cipher_family_sel && key_length_mode == crypto_ctl_pkg::KEY_LEN_10;
    mode_reserved = cipher_family_sel ? key_length_mode == crypto_ctl_pkg::KEY_LEN_11
                                      : key_length_mode == crypto_ctl_pkg::KEY_LEN_10;
  end

endmodule

// ==== design/text_counter.sv ====
`timescale 1ns/1ns
// Variable width counter held in the low bits of the second text register.
module text_counter
#(
  parameter int W = 128
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Control.
  input wire logic [6:0] width_code,
  input wire logic inc,
  input wire logic load_en,
  input wire logic [1:0] load_idx,
  input wire logic [31:0] load_data,
  // Results.
  output logic [W-1:0] value,
  output logic rollover
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic roll;
  } ctr_state_t;

  ctr_state_t s_r;
  ctr_state_t s_nxt;
  logic [W-1:0] mask;
  logic wrap;

  // Width is code plus one; bits above the width are left alone.
  assign mask = {W{1'b1}} >> (crypto_ctl_pkg::CTR_CODE_MAX - width_code);
  assign wrap = (s_r.cnt & mask) == mask;

  // Increment inside the mask; a wrap from all ones raises a one-cycle pulse.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.roll = 1'b0;
    if (inc)
    begin
      s_nxt.cnt = (s_r.cnt & ~mask) | ((s_r.cnt + 1'b1) & mask);
      s_nxt.roll = wrap;
    end
    else if (load_en)
    begin
      s_nxt.cnt[load_idx*32 +: 32] = load_data;
    end
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign value = s_r.cnt;
  assign rollover = s_r.roll;

  AST_ONE_BIT_ROLL: assert property (@(posedge sys_clk) disable iff (srst)
    inc && width_code == 7'h00 && s_r.cnt[0] |=> rollover && !s_r.cnt[0])
    else $error("One bit counter fell from one without rollover.");

  AST_WIDTH_INC: assert property (@(posedge sys_clk) disable iff (srst)
    inc && !wrap |=> (s_r.cnt & $past(mask)) == (($past(s_r.cnt) & $past(mask)) + 1'b1)
      && !rollover)
    else $error("Counter did not step by one within its width.");

endmodule

// ==== design/crypto_key_counter_config.sv ====
`timescale 1ns/1ns
//
// Contract
// - Second text register counts once per counter-mode cipher operation; wrap raises rollover event.
// - Counter width is seven-bit size field plus one, from one to 128 bits.
// - One-bit counter signals rollover when bit zero falls from one.
// - Session key select one uses upper key half, zero the lower half.
// - DES key mode: 11 three-key, 01 two-key, 00 single, 10 reserved.
// - AES key mode: 00 128-bit, 01 192-bit, 10 256-bit, 11 reserved.
// - Writing one to erase bit starts key RAM erase; hardware clears next cycle.
// - Four-bit key source field selects where the cipher key comes from.
// - While go is set, size, key mode and key source writes are ignored.
// - Size field acts only in counter mode using the second text register.
// - Top bit of the control low register is unimplemented, reads zero.
module crypto_key_counter_config
#(
  parameter int CTR_W = crypto_ctl_pkg::CTR_MAX_W
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Cipher datapath.
  input wire logic op_done,
  output logic operation_go,
  output logic module_disable_bit,
  output logic cipher_family_sel,
  // Key configuration toward the engine.
  output logic session_key_half_sel,
  output logic [1:0] key_length_mode,
  output logic [3:0] key_origin_sel,
  output logic key_ram_erase_req,
  output logic des_single,
  output logic des_two_key,
  output logic des_three_key,
  output logic aes_128,
  output logic aes_192,
  output logic aes_256,
  output logic key_mode_reserved,
  // Counter.
  output logic [6:0] counter_width_sel,
  output logic [CTR_W-1:0] text_reg_b,
  output logic counter_rollover,
  // Interrupt.
  output logic irq
);

  typedef struct packed {
    logic [6:0] width;
    logic key_half;
    logic [1:0] key_len;
    logic erase;
    logic [3:0] origin;
    logic go;
    logic disable_mod;
    logic family;
    logic ctr_mode;
    logic [crypto_ctl_pkg::IRQ_W-1:0] sts;
    logic [crypto_ctl_pkg::IRQ_W-1:0] mask;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cfg_state_t;

  cfg_state_t s_r;
  cfg_state_t s_nxt;
  logic ctr_inc;
  logic ctr_load;
  logic do_write;
  logic [31:0] ctl_word;
  logic [31:0] ctrl_word;
  logic [31:0] wr_word;
  logic [31:0] strb_bits;

  ////////////////////////////////////////////////////////////////////////////////

  // Current register images; bit 15 and all upper bits are never stored.
  always_comb
  begin
    ctl_word = crypto_ctl_pkg::ZERO_WORD;
    ctl_word[crypto_ctl_pkg::CTL_CTR_WIDTH_LSB +: 7] = s_r.width;
    ctl_word[crypto_ctl_pkg::CTL_KEY_HALF_BIT] = s_r.key_half;
    ctl_word[crypto_ctl_pkg::CTL_KEY_LEN_LSB +: 2] = s_r.key_len;
    ctl_word[crypto_ctl_pkg::CTL_ERASE_BIT] = s_r.erase;
    ctl_word[crypto_ctl_pkg::CTL_KEY_ORIGIN_LSB +: 4] = s_r.origin;
    ctrl_word = crypto_ctl_pkg::ZERO_WORD;
    ctrl_word[crypto_ctl_pkg::CTRL_GO_BIT] = s_r.go;
    ctrl_word[crypto_ctl_pkg::CTRL_DISABLE_BIT] = s_r.disable_mod;
    ctrl_word[crypto_ctl_pkg::CTRL_FAMILY_BIT] = s_r.family;
    ctrl_word[crypto_ctl_pkg::CTRL_CTR_MODE_BIT] = s_r.ctr_mode;
  end

  // A write executes once both address and data are held and no response waits.
  assign do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
  assign ctr_inc = op_done && s_r.go && s_r.ctr_mode;
  assign ctr_load = do_write && !s_r.go && s_r.awaddr >= crypto_ctl_pkg::OFS_TXTB0
                    && s_r.awaddr <= crypto_ctl_pkg::OFS_TXTB3 && s_r.awaddr[1:0] == 2'h0;
  // Control register writes: strobed bytes take the new data, the others keep the current image; other registers ignore strobes.
  assign strb_bits = {{8{s_r.wstrb[3]}}, {8{s_r.wstrb[2]}}, {8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};
  assign wr_word = (s_r.wdata & strb_bits) | (~strb_bits
                   & (s_r.awaddr == crypto_ctl_pkg::OFS_CTL_LOW ? ctl_word : ctrl_word));

  ////////////////////////////////////////////////////////////////////////////////

  // Next state: bus channels, register writes, hardware updates.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.erase = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (do_write)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = crypto_ctl_pkg::RESP_OKAY;
      case (s_r.awaddr)
        crypto_ctl_pkg::OFS_CTL_LOW:
        begin
          // The engine holds size, key mode and key source stable for a running operation.
          if (!s_r.go)
          begin
            s_nxt.width = wr_word[crypto_ctl_pkg::CTL_CTR_WIDTH_LSB +: 7];
            s_nxt.key_len = wr_word[crypto_ctl_pkg::CTL_KEY_LEN_LSB +: 2];
            s_nxt.origin = wr_word[crypto_ctl_pkg::CTL_KEY_ORIGIN_LSB +: 4];
          end
          s_nxt.key_half = wr_word[crypto_ctl_pkg::CTL_KEY_HALF_BIT];
          s_nxt.erase = wr_word[crypto_ctl_pkg::CTL_ERASE_BIT];
        end
        crypto_ctl_pkg::OFS_CTRL:
        begin
          s_nxt.go = s_r.go | wr_word[crypto_ctl_pkg::CTRL_GO_BIT];
          s_nxt.disable_mod = wr_word[crypto_ctl_pkg::CTRL_DISABLE_BIT];
          s_nxt.family = wr_word[crypto_ctl_pkg::CTRL_FAMILY_BIT];
          s_nxt.ctr_mode = wr_word[crypto_ctl_pkg::CTRL_CTR_MODE_BIT];
        end
        crypto_ctl_pkg::OFS_IRQ_STS:
          s_nxt.sts = s_r.sts & ~s_r.wdata[crypto_ctl_pkg::IRQ_W-1:0];
        crypto_ctl_pkg::OFS_IRQ_MASK:
          s_nxt.mask = s_r.wdata[crypto_ctl_pkg::IRQ_W-1:0];
        default:
        begin
          if (!ctr_load && (s_r.awaddr < crypto_ctl_pkg::OFS_TXTB0
              || s_r.awaddr > crypto_ctl_pkg::OFS_TXTB3 || s_r.awaddr[1:0] != 2'h0))
            s_nxt.bresp = crypto_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end
    // The datapath ends an operation; a done while go is already set wins over a go write in the same cycle.
    if (op_done && s_r.go)
    begin
      s_nxt.go = 1'b0;
      s_nxt.sts[crypto_ctl_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    // Events set after the software clear so that a coinciding event is kept.
    if (counter_rollover)
      s_nxt.sts[crypto_ctl_pkg::IRQ_ROLLOVER_BIT] = 1'b1;
    // Disable forces every control low field to zero and halts the engine.
    if (s_r.disable_mod)
    begin
      s_nxt.width = '0;
      s_nxt.key_half = 1'b0;
      s_nxt.key_len = '0;
      s_nxt.erase = 1'b0;
      s_nxt.origin = '0;
      s_nxt.go = 1'b0;
    end
    // Read channel: one outstanding read, answered one cycle after it is taken.
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = crypto_ctl_pkg::RESP_OKAY;
      s_nxt.rdata = crypto_ctl_pkg::ZERO_WORD;
      case (s_axi_araddr)
        crypto_ctl_pkg::OFS_CTL_LOW: s_nxt.rdata = ctl_word;
        crypto_ctl_pkg::OFS_CTRL: s_nxt.rdata = ctrl_word;
        crypto_ctl_pkg::OFS_IRQ_STS: s_nxt.rdata[crypto_ctl_pkg::IRQ_W-1:0] = s_r.sts;
        crypto_ctl_pkg::OFS_IRQ_MASK: s_nxt.rdata[crypto_ctl_pkg::IRQ_W-1:0] = s_r.mask;
        default:
        begin
          if (s_axi_araddr >= crypto_ctl_pkg::OFS_TXTB0
              && s_axi_araddr <= crypto_ctl_pkg::OFS_TXTB3 && s_axi_araddr[1:0] == 2'h0)
            s_nxt.rdata = text_reg_b[s_axi_araddr[3:2]*32 +: 32];
          else
            s_nxt.rresp = crypto_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Counter for counter-mode operations; width only matters while it steps.
  text_counter #(.W(CTR_W)) u_counter
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .width_code(s_r.width),
    .inc(ctr_inc),
    .load_en(ctr_load),
    .load_idx(s_r.awaddr[3:2]),
    .load_data(s_r.wdata),
    .value(text_reg_b),
    .rollover(counter_rollover)
  );

  // Key mode decode per cipher family.
  key_mode_decode u_decode
  (
    .cipher_family_sel(s_r.family),
    .key_length_mode(s_r.key_len),
    .des_single(des_single),
    .des_two_key(des_two_key),
    .des_three_key(des_three_key),
    .aes_128(aes_128),
    .aes_192(aes_192),
    .aes_256(aes_256),
    .mode_reserved(key_mode_reserved)
  );

  // Outputs; handshake readies are combinational, data come from flip-flops.
  assign s_axi_awready = !s_r.aw_held;
  assign s_axi_wready = !s_r.w_held;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign operation_go = s_r.go;
  assign module_disable_bit = s_r.disable_mod;
  assign cipher_family_sel = s_r.family;
  assign session_key_half_sel = s_r.key_half;
  assign key_length_mode = s_r.key_len;
  assign key_origin_sel = s_r.origin;
  assign key_ram_erase_req = s_r.erase;
  assign counter_width_sel = s_r.width;
  assign irq = |(s_r.sts & s_r.mask);

  ////////////////////////////////////////////////////////////////////////////////

  AST_ERASE_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
    key_ram_erase_req |=> !key_ram_erase_req)
    else $error("Erase request stood longer than one cycle.");

  AST_LOCKED_FIELDS: assert property (@(posedge sys_clk) disable iff (srst)
    operation_go && !module_disable_bit |=> $stable(counter_width_sel)
      && $stable(key_length_mode) && $stable(key_origin_sel))
    else $error("Locked field changed during an operation.");

  AST_DISABLE_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
    module_disable_bit |=> counter_width_sel == 7'h00 && key_length_mode == 2'h0
      && key_origin_sel == 4'h0 && !session_key_half_sel && !operation_go)
    else $error("Fields not cleared while disabled.");

  AST_TOP_BIT_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == crypto_ctl_pkg::OFS_CTL_LOW
      |=> s_axi_rvalid && s_axi_rdata[15:0] == {1'b0, $past(ctl_word[14:0])})
    else $error("Control low readback wrong or top bit set.");

  AST_ROLL_PULSE: assert property (@(posedge sys_clk) disable iff (srst)
    counter_rollover |=> !counter_rollover ##0 s_r.sts[crypto_ctl_pkg::IRQ_ROLLOVER_BIT])
    else $error("Rollover not a single pulse or not latched.");

  AST_NO_COUNT_OUTSIDE: assert property (@(posedge sys_clk) disable iff (srst)
    !s_r.ctr_mode && !ctr_load |=> $stable(text_reg_b) && !counter_rollover)
    else $error("Counter moved outside counter mode.");

  AST_DES_DECODE: assert property (@(posedge sys_clk) disable iff (srst)
    !cipher_family_sel |-> (des_three_key == (key_length_mode == 2'h3))
      && (key_mode_reserved == (key_length_mode == 2'h2)) && !aes_128)
    else $error("DES key mode decoded wrongly.");

  AST_AES_DECODE: assert property (@(posedge sys_clk) disable iff (srst)
    cipher_family_sel |-> (aes_256 == (key_length_mode == 2'h2))
      && (aes_128 == (key_length_mode == 2'h0)) && !des_single)
    else $error("AES key mode decoded wrongly.");

  AST_COUNT_ON_DONE: assert property (@(posedge sys_clk) disable iff (srst)
    ctr_inc && text_reg_b[0] == 1'b0 |=> text_reg_b[0] && !operation_go)
    else $error("Counter did not step after an operation.");

endmodule

// ==== verif/tb_crypto_key_counter_config.sv ====
`timescale 1ns/1ns
module tb_crypto_key_counter_config;

  // Short names for the register byte offsets.
  localparam logic [7:0] A_LOW = crypto_ctl_pkg::OFS_CTL_LOW;
  localparam logic [7:0] A_CTRL = crypto_ctl_pkg::OFS_CTRL;
  localparam logic [7:0] A_STS = crypto_ctl_pkg::OFS_IRQ_STS;
  localparam logic [7:0] A_MASK = crypto_ctl_pkg::OFS_IRQ_MASK;
  localparam logic [7:0] A_TXT0 = crypto_ctl_pkg::OFS_TXTB0;
  localparam logic [1:0] OK = crypto_ctl_pkg::RESP_OKAY;
  localparam logic [1:0] BAD = crypto_ctl_pkg::RESP_SLVERR;

  typedef struct {
    logic [6:0] code;
    logic mode;
    logic [31:0] i0;
    logic [31:0] i1;
    logic [31:0] e0;
    logic [31:0] e1;
    logic roll;
  } ctr_case_t;

  // Bus master and datapath stimulus, all idle at time zero.
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] aw_addr = 8'h00;
  logic [7:0] ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0000_0000;
  logic [3:0] w_strb = 4'hF;
  logic aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
  logic op_done = 1'b0;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, go, dis, fam, half, erase, roll;
  logic [1:0] b_resp, r_resp, klen;
  logic [31:0] r_data;
  logic [3:0] origin;
  logic [6:0] wsel, dec;
  logic [127:0] txt;
  int n_errors = 0, checks_done = 0, erase_cnt = 0, roll_cnt = 0;

  // Counter rows: width code, counter mode, start words, expected words, wrap.
  ctr_case_t cs [8] = '{
    '{7'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{7'h02, 1'b1, 32'h0000_000F, 32'h0000_0000, 32'h0000_0008, 32'h0000_0000, 1'b1},
    '{7'h02, 1'b1, 32'h0000_0005, 32'h0000_0000, 32'h0000_0006, 32'h0000_0000, 1'b0},
    '{7'h02, 1'b1, 32'h0000_0004, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000, 1'b0},
    '{7'h02, 1'b0, 32'h0000_0005, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000, 1'b0},
    '{7'h1F, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{7'h20, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{7'h20, 1'b1, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 1'b1}
  };

  crypto_key_counter_config u_crypto_key_counter_config
  (
    .sys_clk(sys_clk), .srst(srst),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld), .s_axi_rready(r_rdy),
    .op_done(op_done), .operation_go(go), .module_disable_bit(dis), .cipher_family_sel(fam),
    .session_key_half_sel(half), .key_length_mode(klen), .key_origin_sel(origin),
    .key_ram_erase_req(erase), .des_single(dec[6]), .des_two_key(dec[5]),
    .des_three_key(dec[4]), .aes_128(dec[3]), .aes_192(dec[2]), .aes_256(dec[1]),
    .key_mode_reserved(dec[0]), .counter_width_sel(wsel), .text_reg_b(txt),
    .counter_rollover(roll), .irq(irq)
  );

  // Free running clock at 20 MHz.
  always #25 sys_clk = ~sys_clk;

  // Count cycles of the two pulses; a stuck pulse shows up as a count above one.
  always @(posedge sys_clk)
  begin
    if (erase === 1'b1) erase_cnt++;
    if (roll === 1'b1) roll_cnt++;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per kind of result.
  task automatic report(input string kind, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, kind, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    report("read word", got, exp);
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    report("response", {30'h0, got}, {30'h0, exp});
  endtask

  task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
    report("port level", got, exp);
  endtask

  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Bus tasks. Each opens with a clock edge so no signal is driven twice in one time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic got;
    @(posedge sys_clk);
    n = 0;
    got = 1'b0;
    aw_addr <= a;
    w_data <= d;
    aw_vld <= 1'b1;
    w_vld <= 1'b1;
    b_rdy <= 1'b1;
    while (!got)
    begin
      @(posedge sys_clk);
      if (aw_vld && aw_rdy) aw_vld <= 1'b0;
      if (w_vld && w_rdy) w_vld <= 1'b0;
      if (b_vld === 1'b1 && b_rdy)
      begin
        got = 1'b1;
        b_rdy <= 1'b0;
        chk_resp(b_resp, er);
      end
      n++;
      if (n > 100)
      begin
        n_errors++;
        close_out();
      end
    end
  endtask

  // A read compares the returned word and code at once.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    logic got;
    @(posedge sys_clk);
    n = 0;
    got = 1'b0;
    ar_addr <= a;
    ar_vld <= 1'b1;
    r_rdy <= 1'b1;
    while (!got)
    begin
      @(posedge sys_clk);
      if (ar_vld && ar_rdy) ar_vld <= 1'b0;
      if (r_vld === 1'b1 && r_rdy)
      begin
        got = 1'b1;
        r_rdy <= 1'b0;
        chk_word(r_data, exp);
        chk_resp(r_resp, er);
      end
      n++;
      if (n > 100)
      begin
        n_errors++;
        close_out();
      end
    end
  endtask

  task automatic pulse_done();
    @(posedge sys_clk);
    op_done <= 1'b1;
    @(posedge sys_clk);
    op_done <= 1'b0;
  endtask

  // Expected one-hot decode: des single, two, three key, aes 128, 192, 256, reserved.
  function automatic logic [6:0] exp_dec(input logic f, input logic [1:0] m);
    if (f) return {3'b000, m == 2'h0, m == 2'h1, m == 2'h2, m == 2'h3};
    return {m == 2'h0, m == 2'h1, m == 2'h3, 3'b000, m == 2'h2};
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    int e0;
    int r0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rd(A_LOW, 32'h0000_0000, OK);
    rd(A_CTRL, 32'h0000_0000, OK);
    rd(A_STS, 32'h0000_0000, OK);
    rd(8'h40, 32'h0000_0000, BAD);
    wr(8'h40, 32'h0000_0001, BAD);
    $display("Test reset_and_map done");
    e0 = erase_cnt;
    wr(A_LOW, 32'hFFFF_FFFF, OK);
    repeat (3) @(posedge sys_clk);
    chk_port(erase_cnt - e0, 32'h0000_0001);
    rd(A_LOW, 32'h0000_7FEF, OK);
    chk_port({half, klen, origin, wsel}, {18'h0, 1'b1, 2'h3, 4'hF, 7'h7F});
    // Only byte one is strobed: the width clears and the low byte keeps its bits.
    w_strb <= 4'h2;
    wr(A_LOW, 32'h0000_0000, OK);
    w_strb <= 4'hF;
    rd(A_LOW, 32'h0000_00EF, OK);
    $display("Test field_readback done");
    for (int f = 0; f < 2; f++)
      for (int m = 0; m < 4; m++)
      begin
        wr(A_CTRL, 32'(f << 2), OK);
        wr(A_LOW, 32'(m << 5), OK);
        chk_port({fam, half, dec}, {f[0], 1'b0, exp_dec(f[0], m[1:0])});
      end
    $display("Test key_decode done");
    // Locked fields must hold while go is set; key half and erase stay writable.
    wr(A_CTRL, 32'h0000_0000, OK);
    wr(A_LOW, 32'h0000_0305, OK);
    wr(A_CTRL, 32'h0000_0001, OK);
    chk_port({29'h0, go, dis, fam}, 32'h0000_0004);
    wr(A_LOW, 32'h0000_7FEF, OK);
    rd(A_LOW, 32'h0000_0385, OK);
    pulse_done();
    repeat (4) @(posedge sys_clk);
    rd(A_CTRL, 32'h0000_0000, OK);
    wr(A_STS, 32'h0000_0003, OK);
    $display("Test write_lock done");
    wr(A_LOW, 32'h0000_12A3, OK);
    wr(A_CTRL, 32'h0000_0002, OK);
    chk_port({29'h0, go, dis, fam}, 32'h0000_0002);
    rd(A_LOW, 32'h0000_0000, OK);
    chk_port({half, klen, origin, wsel}, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0000, OK);
    $display("Test disable_clear done");
    // Only rollover is unmasked, so a bare completion must leave irq low.
    wr(A_MASK, 32'h0000_0001, OK);
    rd(A_MASK, 32'h0000_0001, OK);
    foreach (cs[i])
    begin
      r0 = roll_cnt;
      wr(A_LOW, {17'h0_0000, cs[i].code, 8'h00}, OK);
      wr(A_TXT0, cs[i].i0, OK);
      wr(A_TXT0 + 8'h04, cs[i].i1, OK);
      wr(A_CTRL, {28'h000_0000, cs[i].mode, 3'h1}, OK);
      pulse_done();
      repeat (4) @(posedge sys_clk);
      chk_port(roll_cnt - r0, {31'h0, cs[i].roll});
      chk_port({31'h0, irq}, {31'h0, cs[i].roll});
      rd(A_TXT0, cs[i].e0, OK);
      rd(A_TXT0 + 8'h04, cs[i].e1, OK);
      chk_port(txt[31:0], cs[i].e0);
      chk_port(txt[63:32] | txt[95:64] | txt[127:96], cs[i].e1);
      rd(A_STS, {30'h0, 1'b1, cs[i].roll}, OK);
      wr(A_STS, 32'h0000_0003, OK);
      chk_port({31'h0, irq}, 32'h0000_0000);
      rd(A_CTRL, {28'h000_0000, cs[i].mode, 3'h0}, OK);
    end
    // The upper counter words are reachable as plain storage while idle.
    wr(A_TXT0 + 8'h0C, 32'hA5A5_0001, OK);
    rd(A_TXT0 + 8'h0C, 32'hA5A5_0001, OK);
    rd(A_TXT0 + 8'h08, 32'h0000_0000, OK);
    chk_port(txt[127:96], 32'hA5A5_0001);
    $display("Test counter done");
    close_out();
  end

endmodule
